/* File: design/fps_pkg.sv */
// constants, register map and state type of the flash protection/status block
// assumes the block is clocked by pclk with registers reached over apb
package fps_pkg;
  localparam logic [31:0] SEC_ADDR      = 32'h4004_0500;
  localparam logic [31:0] STAT_ADDR     = 32'h4004_0520;
  localparam logic        SEC_RST       = 1'b1;
  localparam int          NBLK          = 6;
  localparam int          STAT_PROT_LSB = 16;
  localparam int          ID_SEL_LSB    = 14;
  // command address and data bytes of the unlock sequence
  localparam logic [7:0]  SEQ_A1        = 8'h54;
  localparam logic [7:0]  SEQ_A2        = 8'hAA;
  localparam logic [7:0]  SEQ_D1        = 8'hAA;
  localparam logic [7:0]  SEQ_D2        = 8'h55;
  localparam logic [7:0]  CMD_READ      = 8'hF0;
  localparam logic [7:0]  CMD_IDQ       = 8'h90;
  localparam logic [7:0]  CMD_PERASE    = 8'h6A;
  localparam logic [2:0]  STEP_CMD      = 3'h2;
  localparam logic [2:0]  STEP_PERASE2  = 3'h3;
  localparam logic [2:0]  STEP_LAST     = 3'h6;
  // read block after reset
  localparam int          CLK_PERIOD_NS = 100;
  localparam int          RD_BLOCK_NS   = 2_000_000;
  localparam int          RD_BLOCK_CYC  = (RD_BLOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  typedef enum logic [2:0] {
    ST_IDLE, ST_F_ARR, ST_F_PROT, ST_P_PROT, ST_P_ARR, ST_FAIL
  } fps_state_e;
endpackage : fps_pkg

/* File: design/fps_flash_ctrl.sv */
// flash protection erase, id query mode, status and security registers
// assumes the array engine answers each erase request with one op_done or op_fail pulse
//
// Contract
// - all protected: erase array, then protection bits
// - full erase done: status reads 0x00000001
// - partial: clear all bits, array left erased
// - partial done: selected protection flags read zero
// - commands ignored while protection erase runs
// - normal end returns to array read
// - ready flag low while busy, high after
// - id value chosen by address bits 15:14
// - id mode reads return id value
// - id mode holds until reset command/reset; the code also leaves id mode when a protection erase starts
// - failed operation keeps ready low until reset
// - status bits 21:16 show block protection
// - protection flags load from nonvolatile state
// - array reads blocked about 2 ms after reset
// - security bit 0, rw, power-on reset only
// - full case needs security bit set
`timescale 1ns/1ps
`default_nettype none
module fps_flash_ctrl #(
  parameter int          RD_BLOCK = fps_pkg::RD_BLOCK_CYC,
  parameter logic [127:0] ID_TABLE = 128'h0000_0003_0000_0002_0000_0001_0000_0000 // arbitrary
) (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   por_n,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [31:0]            paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic                   fl_wr_en,
  input  wire logic [31:0]            fl_addr,
  input  wire logic [31:0]            fl_wdata,
  input  wire logic                   fl_rd_en,
  output logic      [31:0]            fl_rdata,
  output logic                        fl_rvalid,
  output logic                        fl_rd_ok,
  input  wire logic [31:0]            arr_rdata,
  output logic                        arr_erase_req,
  output logic                        prot_clear_req,
  input  wire logic                   op_done,
  input  wire logic                   op_fail,
  input  wire logic [fps_pkg::NBLK-1:0] nv_protect,
  output logic      [fps_pkg::NBLK-1:0] block_protect_flag,
  output logic                        ready_busy_flag,
  output logic                        id_mode
);
  localparam int BW = $clog2(RD_BLOCK + 1);

  fps_pkg::fps_state_e st_q, st_d;
  logic [2:0]               cnt_q, cnt_d;
  logic                     idm_q, idm_d;
  logic [1:0]               idsel_q, idsel_d;
  logic [fps_pkg::NBLK-1:0] prot_q, prot_d;
  logic                     ld_q;
  logic                     arr_q, arr_d, pclr_q, pclr_d;
  logic                     sec_q, sec_d;
  logic [BW-1:0]            blk_q, blk_d;
  logic [31:0]              rd_q, rd_d, prd_q, prd_d;
  logic                     rv_q, rv_d;
  logic                     start_w, full_w, step_ok;
  logic [31:0]              status_w;

  // one write of the unlock/command sequence is accepted at step cnt
  function automatic logic seq_ok(input logic [2:0] cnt, input logic [7:0] a,
                                  input logic [7:0] d);
    case (cnt)
      3'h0, 3'h3: seq_ok = (a == fps_pkg::SEQ_A1) && (d == fps_pkg::SEQ_D1);
      3'h1, 3'h4: seq_ok = (a == fps_pkg::SEQ_A2) && (d == fps_pkg::SEQ_D2);
      3'h2:       seq_ok = (a == fps_pkg::SEQ_A1);
      3'h5:       seq_ok = (a == fps_pkg::SEQ_A1) && (d == fps_pkg::CMD_PERASE);
      3'h6:       seq_ok = (d == fps_pkg::CMD_PERASE);
      default:    seq_ok = 1'b0;
    endcase
  endfunction : seq_ok

  function automatic logic [31:0] id_word(input logic [1:0] sel);
    id_word = ID_TABLE[32*sel +: 32];
  endfunction : id_word

  // full case only when every block is protected and security is on
  assign full_w   = (&prot_q) && sec_q;
  assign step_ok  = seq_ok(cnt_q, fl_addr[15:8], fl_wdata[7:0]);
  assign start_w  = (st_q == fps_pkg::ST_IDLE) && fl_wr_en && step_ok
                    && (cnt_q == fps_pkg::STEP_LAST);
  assign status_w = {10'h000, prot_q, 15'h0000, (st_q == fps_pkg::ST_IDLE)};

  // command sequencer and protection erase engine
  always_comb
  begin
    st_d    = st_q;
    cnt_d   = cnt_q;
    idm_d   = idm_q;
    idsel_d = idsel_q;
    prot_d  = prot_q;
    arr_d   = 1'b0;
    pclr_d  = 1'b0;
    if (ld_q)
    begin
      prot_d = nv_protect;
    end
    case (st_q)
      fps_pkg::ST_IDLE:
      begin
        if (fl_wr_en)
        begin
          if (fl_wdata[7:0] == fps_pkg::CMD_READ && cnt_q == 3'h0)
          begin
            idm_d = 1'b0; // single-write read command also leaves id mode
          end
          else if (step_ok)
          begin
            cnt_d = cnt_q + 3'h1;
            if (cnt_q == fps_pkg::STEP_CMD)
            begin
              cnt_d = 3'h0;
              if (fl_wdata[7:0] == fps_pkg::CMD_IDQ)
              begin
                idm_d = 1'b1;
              end
              else if (fl_wdata[7:0] == fps_pkg::CMD_READ)
              begin
                idm_d = 1'b0;
              end
              else if (fl_wdata[7:0] == fps_pkg::CMD_PERASE)
              begin
                cnt_d = fps_pkg::STEP_PERASE2;
              end
            end
            else if (cnt_q == fps_pkg::STEP_LAST)
            begin
              cnt_d = 3'h0;
              idm_d = 1'b0;
              if (full_w)
              begin
                st_d  = fps_pkg::ST_F_ARR; // array first
                arr_d = 1'b1;
              end
              else
              begin
                st_d   = fps_pkg::ST_P_PROT; // all bits at once
                pclr_d = 1'b1;
              end
            end
          end
          else if (idm_q && cnt_q == 3'h0)
          begin
            idsel_d = fl_addr[fps_pkg::ID_SEL_LSB +: 2]; // repeatable select write
          end
          else
          begin
            cnt_d = 3'h0; // broken sequence restarts at step 0, id mode unchanged
          end
        end
      end
      // busy states take no writes at all
      fps_pkg::ST_F_ARR:
      begin
        if (op_fail)
        begin
          st_d = fps_pkg::ST_FAIL;
        end
        else if (op_done)
        begin
          st_d   = fps_pkg::ST_F_PROT; // then the protection bits
          pclr_d = 1'b1;
        end
      end
      fps_pkg::ST_F_PROT:
      begin
        if (op_fail)
        begin
          st_d = fps_pkg::ST_FAIL;
        end
        else if (op_done)
        begin
          prot_d = '0; // status becomes 0x00000001
          st_d   = fps_pkg::ST_IDLE;
        end
      end
      fps_pkg::ST_P_PROT:
      begin
        if (op_fail)
        begin
          st_d = fps_pkg::ST_FAIL;
        end
        else if (op_done)
        begin
          prot_d = '0; // selected flags cleared
          st_d   = fps_pkg::ST_P_ARR; // blocks left erased
          arr_d  = 1'b1;
        end
      end
      fps_pkg::ST_P_ARR:
      begin
        if (op_fail)
        begin
          st_d = fps_pkg::ST_FAIL;
        end
        else if (op_done)
        begin
          st_d = fps_pkg::ST_IDLE;
        end
      end
      fps_pkg::ST_FAIL: st_d = fps_pkg::ST_FAIL; // only reset leaves
      default: st_d = fps_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q    <= fps_pkg::ST_IDLE;
      cnt_q   <= 3'h0;
      idm_q   <= 1'b0;
      idsel_q <= 2'h0;
      prot_q  <= '0;
      ld_q    <= 1'b1;
      arr_q   <= 1'b0;
      pclr_q  <= 1'b0;
    end
    else
    begin
      st_q    <= st_d;
      cnt_q   <= cnt_d;
      idm_q   <= idm_d;
      idsel_q <= idsel_d;
      prot_q  <= prot_d;
      ld_q    <= 1'b0;
      arr_q   <= arr_d;
      pclr_q  <= pclr_d;
    end
  end

  // flash read path; reads after system reset (presetn) wait out the array recovery
  always_comb
  begin
    blk_d = blk_q;
    rd_d  = rd_q;
    rv_d  = 1'b0;
    if (blk_q != '0)
    begin
      blk_d = blk_q - BW'(1);
    end
    else if (fl_rd_en)
    begin
      rv_d = 1'b1;
      rd_d = idm_q ? id_word(idsel_q) : arr_rdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      blk_q <= BW'(RD_BLOCK);
      rd_q  <= 32'h0000_0000;
      rv_q  <= 1'b0;
    end
    else
    begin
      blk_q <= blk_d;
      rd_q  <= rd_d;
      rv_q  <= rv_d;
    end
  end

  // apb: read data latched in setup, so access always completes in one cycle
  always_comb
  begin
    prd_d = prd_q;
    sec_d = sec_q;
    if (psel && !penable)
    begin
      prd_d = (paddr == fps_pkg::STAT_ADDR) ? status_w :
              (paddr == fps_pkg::SEC_ADDR)  ? {31'h0000_0000, sec_q} : 32'h0000_0000;
    end
    if (psel && penable && pwrite && paddr == fps_pkg::SEC_ADDR)
    begin
      sec_d = pwdata[0]; // upper bits discarded
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prd_q <= 32'h0000_0000;
    end
    else
    begin
      prd_q <= prd_d;
    end
  end

  // security bit survives system reset, set state restored only by power-on
  always_ff @(posedge pclk or negedge por_n)
  begin
    if (!por_n)
    begin
      sec_q <= fps_pkg::SEC_RST;
    end
    else
    begin
      sec_q <= sec_d;
    end
  end

  assign prdata             = prd_q;
  assign pready             = 1'b1;
  assign pslverr            = psel && penable && (paddr != fps_pkg::STAT_ADDR)
                              && (paddr != fps_pkg::SEC_ADDR);
  assign fl_rdata           = rd_q;
  assign fl_rvalid          = rv_q;
  assign fl_rd_ok           = (blk_q == '0);
  assign arr_erase_req      = arr_q;
  assign prot_clear_req     = pclr_q;
  assign block_protect_flag = prot_q; // writes to set blocks must be refused
  assign ready_busy_flag    = (st_q == fps_pkg::ST_IDLE);
  assign id_mode            = idm_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_full_prot_done;
    st_q == fps_pkg::ST_F_PROT && op_done && !op_fail;
  endsequence
  sequence s_part_prot_done;
    st_q == fps_pkg::ST_P_PROT && op_done && !op_fail;
  endsequence

  full_erase_a: assert property (start_w && full_w |=> arr_erase_req && st_q == fps_pkg::ST_F_ARR)
    else $error("full protection erase did not start with array erase");
  done_status_a: assert property (s_full_prot_done |=> status_w == 32'h0000_0001)
    else $error("status not 0x1 after full protection erase");
  part_order_a: assert property (start_w && !full_w |=> prot_clear_req ##0 !ready_busy_flag)
    else $error("partial erase did not clear protection first");
  part_clear_a: assert property (s_part_prot_done |=> prot_q == '0 && arr_erase_req)
    else $error("partial erase left flags set or skipped array erase");
  busy_ignore_a: assert property (st_q != fps_pkg::ST_IDLE |=> $stable(cnt_q) && $stable(idsel_q))
    else $error("command accepted while busy");
  back_read_a: assert property (st_q == fps_pkg::ST_P_ARR && op_done && !op_fail |=> ready_busy_flag && !id_mode)
    else $error("no return to read mode after erase");
  busy_flag_a: assert property (start_w |=> !ready_busy_flag [*2])
    else $error("ready flag high while operation runs");
  fail_hold_a: assert property (st_q == fps_pkg::ST_FAIL |=> !ready_busy_flag && st_q == fps_pkg::ST_FAIL)
    else $error("ready returned after a failed operation");
  identification_query_cmd_a: assert property (fl_rd_en && fl_rd_ok && id_mode |=> fl_rvalid && fl_rdata == id_word($past(idsel_q)))
    else $error("id mode read returned array data");
  rd_block_a: assert property ($rose(presetn) |-> !fl_rd_ok)
    else $error("array reads enabled right after reset");
endmodule : fps_flash_ctrl
`default_nettype wire

/* File: testbench/fps_array_model.sv */
// array engine stand-in that answers erase requests of the flash controller
// assumes one-cycle request pulses and one outstanding request at a time
`timescale 1ns/1ps
`default_nettype none
module fps_array_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       arr_erase_req,
  input  wire logic       prot_clear_req,
  input  wire logic       fail_mode,
  input  wire logic [4:0] dly,
  output logic            op_done,
  output logic            op_fail
);
  logic [4:0] cnt_q;
  logic [4:0] cnt_d;
  // load the delay on a request, count down, answer at one
  always_comb
  begin
    cnt_d = cnt_q;
    if (arr_erase_req || prot_clear_req)
      cnt_d = dly;
    else if (cnt_q != 5'h0)
      cnt_d = cnt_q - 5'h1;
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_q <= 5'h0;
    else
      cnt_q <= cnt_d;
  end
  // dly of one or more keeps the answer at least a cycle after the request
  assign op_done = (cnt_q == 5'h1) && !fail_mode;
  assign op_fail = (cnt_q == 5'h1) && fail_mode;
endmodule : fps_array_model
`default_nettype wire

/* File: testbench/flash_protect_erase_idread_status_tb.sv */
// self-checking bench for the flash protection, id query and status block
// assumes 10 MHz pclk, a zero-wait apb slave and the array model behind it
`timescale 1ns/1ps
`default_nettype none
module flash_protect_erase_idread_status_tb;
  localparam logic [31:0] STA = fps_pkg::STAT_ADDR;
  localparam logic [31:0] SEC = fps_pkg::SEC_ADDR;
  logic        pclk, pready, pslverr, fl_rvalid, fl_rd_ok, id_mode, ready_busy_flag;
  logic        presetn = 1'b0, por_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        fl_wr_en = 1'b0, fl_rd_en = 1'b0, fail_mode = 1'b0;
  logic        arr_erase_req, prot_clear_req, op_done, op_fail;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, fl_addr = 32'h0, fl_wdata = 32'h0;
  logic [31:0] arr_rdata = 32'h0, prdata, fl_rdata;
  logic [5:0]  nv_protect = 6'h15, block_protect_flag;
  logic [4:0]  dly = 5'h6;
  logic [3:0]  ord = 4'h0;
  logic [31:0] exp_q[$];
  int          fail_count = 0, num_checks = 0, cyc = 0, seed;

  fps_flash_ctrl #(.RD_BLOCK(8)) dut (.pclk(pclk), .presetn(presetn), .por_n(por_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .fl_wr_en(fl_wr_en),
    .fl_addr(fl_addr), .fl_wdata(fl_wdata), .fl_rd_en(fl_rd_en), .fl_rdata(fl_rdata),
    .fl_rvalid(fl_rvalid), .fl_rd_ok(fl_rd_ok), .arr_rdata(arr_rdata),
    .arr_erase_req(arr_erase_req), .prot_clear_req(prot_clear_req), .op_done(op_done),
    .op_fail(op_fail), .nv_protect(nv_protect), .block_protect_flag(block_protect_flag),
    .ready_busy_flag(ready_busy_flag), .id_mode(id_mode));
  fps_array_model eng (.pclk(pclk), .presetn(presetn), .arr_erase_req(arr_erase_req),
    .prot_clear_req(prot_clear_req), .fail_mode(fail_mode), .dly(dly),
    .op_done(op_done), .op_fail(op_fail));

  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic close_out();
    if (fail_count == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : close_out

  // pair each finished read with the oldest expectation; an extra read is a mismatch
  always @(posedge pclk)
  begin
    if ((psel && penable && pready && !pwrite) || fl_rvalid)
    begin
      if (exp_q.size() == 0)
        chk(32'hx, 32'h0);
      else
        chk(fl_rvalid ? fl_rdata : prdata, exp_q.pop_front());
    end
  end

  // order of erase requests, two bits per request
  always @(posedge pclk)
    if (arr_erase_req || prot_clear_req)
      ord <= {ord[1:0], prot_clear_req, arr_erase_req};

  // hang guard; a normal run is near three hundred cycles
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      fail_count++;
      close_out();
    end
  end

  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no wait-state count is assumed; only the hang guard ends this wait
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (!pready);
    chk({31'h0, pslverr}, {31'h0, (a != STA) && (a != SEC)}); // unmapped flagged
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : rd

  task automatic fw(input logic [7:0] a, input logic [7:0] d);
    @(posedge pclk);
    fl_wr_en <= 1'b1;
    fl_addr  <= {16'h0000, a, 8'h00};
    fl_wdata <= {24'h0, d};
    @(posedge pclk);
    fl_wr_en <= 1'b0;
  endtask : fw

  // m: 0 array data expected, 1 id word k expected, 2 no answer expected
  task automatic fr(input logic [1:0] m, input logic [1:0] k);
    logic [31:0] r;
    r = $random(seed);
    @(posedge pclk);
    fl_rd_en  <= 1'b1;
    arr_rdata <= r;
    if (m == 2'd0)
      exp_q.push_back(r);
    if (m == 2'd1)
      exp_q.push_back({30'h0, k});
    @(posedge pclk);
    fl_rd_en  <= 1'b0;
    arr_rdata <= ~r;
    @(posedge pclk);
  endtask : fr

  task automatic seq3(input logic [7:0] c);
    fw(8'h54, 8'hAA);
    fw(8'hAA, 8'h55);
    fw(8'h54, c);
  endtask : seq3

  task automatic erase();
    seq3(8'h6A);
    seq3(8'h6A);
    fw(8'h3C, 8'h6A);
  endtask : erase

  // only issue commands once ready again
  task automatic waitr();
    int n = 0;
    // look at the falling edge so the flag has settled after the last command write
    repeat (2) @(negedge pclk);
    while (!ready_busy_flag && n < 300)
    begin
      @(negedge pclk);
      n++;
    end
    chk({31'h0, ready_busy_flag}, 32'h1); // ready after the run
  endtask : waitr

  // reset held eight cycles, well over half a microsecond
  task automatic hrst(input logic [5:0] nv);
    @(posedge pclk);
    presetn    <= 1'b0;
    nv_protect <= nv;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    por_n   <= 1'b1; // hold time
  endtask : hrst

  initial
  begin
    seed = 32'h612c;
    hrst(6'h15);
    fr(2'd2, 2'd0); // reads refused right after reset
    chk({31'h0, fl_rd_ok}, 32'h0); // still blocked
    repeat (10) @(posedge pclk);
    chk({31'h0, fl_rd_ok}, 32'h1); // reads open again
    rd(STA, 32'h0015_0001); // flags from stored state
    chk({26'h0, block_protect_flag}, 32'h15); // per-block flags
    rd(SEC, 32'h1); // security powers up set
    apb(1'b1, STA, 32'hFFFF_FFFF);
    rd(STA, 32'h0015_0001); // read-only status
    apb(1'b1, SEC, {$random(seed)} & 32'hFFFF_FFFE);
    rd(SEC, 32'h0); // bit 0 writable, rest zero
    apb(1'b1, 32'h4004_0504, 32'hFFFF_FFFF);
    rd(32'h4004_0504, 32'h0); // unmapped reads zero
    erase();
    repeat (2) @(posedge pclk);
    rd(STA, 32'h0015_0000); // busy while running
    seq3(8'h90); // id entry while busy
    waitr();
    rd(STA, 32'h1); // partial done, flags cleared
    chk({28'h0, ord}, 32'h9); // clear then array erase
    fr(2'd0, 2'd0); // array read, id entry ignored
    apb(1'b1, SEC, 32'h0);
    hrst(6'h3F);
    rd(SEC, 32'h0); // system reset keeps security
    apb(1'b1, SEC, 32'h1);
    dly <= 5'h14;
    erase();
    waitr();
    chk({28'h0, ord}, 32'h6); // array first, then protection
    rd(STA, 32'h1); // full erase status word
    seq3(8'h90);
    for (int k = 0; k < 4; k++)
    begin
      fw({k[1:0], 6'h00}, 8'h00); // select by address bits
      fr(2'd1, k[1:0]); // id word returned, mode held
      chk({31'h0, id_mode}, 32'h1); // mode persists
    end
    fw(8'h00, 8'hF0);
    fr(2'd0, 2'd0); // back to array after read/reset
    chk({31'h0, id_mode}, 32'h0); // mode left
    fail_mode <= 1'b1;
    erase();
    repeat (30) @(posedge pclk);
    rd(STA, 32'h0); // failed run stays busy
    hrst(6'h07);
    fail_mode <= 1'b0;
    rd(STA, 32'h0007_0001); // recheck flags after abort
    erase();
    waitr();
    rd(STA, 32'h1); // rerun completes
    repeat (4) @(posedge pclk);
    close_out();
  end
endmodule : flash_protect_erase_idread_status_tb
`default_nettype wire
